// ==== twirq_regs.sv ====
`timescale 1ns/1ns
module twirq_regs
   import twirq_pkg::*;
#(
   parameter int DW = 8
)
(
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic rx_load, // Shifter delivers a received byte
   input wire logic [DW-1:0] rx_load_byte, // Received byte
   input wire logic tx_take, // Shifter takes the transmit byte
   output logic [DW-1:0] tx_byte, // Byte for the shifter
   input wire logic transfer_complete, // Status source from the engine
   input wire logic slave_addressed, // Status source from the engine
   input wire logic general_call_seen, // Status source from the engine
   input wire logic not_acknowledged, // Status source from the engine
   input wire logic arbitration_lost, // Status source from the engine
   input wire logic clock_stretch_wait, // Status source from the engine
   input wire logic slave_access_done, // Status source from the engine
   output logic rx_overrun, // Byte landed while still full, pulse
   output logic [TWIRQ_FLAG_W-1:0] flag_register, // Live flag vector
   output logic irq // Level interrupt
);
   logic [TWIRQ_FLAG_W-1:0] mask_reg;
   logic [TWIRQ_FLAG_W-1:0] mask_next;
   logic [TWIRQ_EVT_W-1:0] evt_reg;
   logic [TWIRQ_EVT_W-1:0] evt_mask_reg;
   logic [TWIRQ_EVT_W-1:0] evt_set;
   logic [31:0] prdata_reg;
   logic [31:0] rd_next;
   logic ovr_reg;
   logic wr_en;
   logic rd_en;
   logic rx_hold_take;
   logic tx_hold_put;
   logic rx_holding_full;
   logic tx_holding_free;
   logic ovr_pulse;
   logic [DW-1:0] rx_byte;
   logic bad_addr;

   // Zero wait state slave: every access ends in its first access cycle
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign rx_hold_take = rd_en && (paddr == TWIRQ_OFF_RX_HOLD);
   assign tx_hold_put = wr_en && (paddr == TWIRQ_OFF_TX_HOLD);

   twirq_rx_hold #(.DW(DW)) u_rx
   (
      .pclk(pclk),
      .presetn(presetn),
      .load(rx_load),
      .load_byte(rx_load_byte),
      .take(rx_hold_take),
      .rx_byte(rx_byte),
      .full(rx_holding_full),
      .overrun(ovr_pulse)
   );

   twirq_tx_hold #(.DW(DW)) u_tx
   (
      .pclk(pclk),
      .presetn(presetn),
      .put(tx_hold_put),
      .put_byte(pwdata[DW-1:0]),
      .take(tx_take),
      .tx_byte(tx_byte),
      .free(tx_holding_free)
   );

   // Overrun is sticky until the flag word is read; a new overrun wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovr_reg <= 1'b0;
      else if (ovr_pulse)
         ovr_reg <= 1'b1;
      else if (rd_en && paddr == TWIRQ_OFF_FLAGS)
         ovr_reg <= 1'b0;
   end
   assign rx_overrun = ovr_pulse;

   // Live flag vector in the shared layout
   always_comb
   begin
      flag_register = '0;
      flag_register[TWIRQ_B_DONE] = transfer_complete;
      flag_register[TWIRQ_B_RXFULL] = rx_holding_full;
      flag_register[TWIRQ_B_TXFREE] = tx_holding_free;
      flag_register[TWIRQ_B_SLVADDR] = slave_addressed;
      flag_register[TWIRQ_B_GCALL] = general_call_seen;
      flag_register[TWIRQ_B_OVR] = ovr_reg;
      flag_register[TWIRQ_B_NOT_ACKNOWLEDGED] = not_acknowledged;
      flag_register[TWIRQ_B_ARB] = arbitration_lost;
      flag_register[TWIRQ_B_WAIT] = clock_stretch_wait;
      flag_register[TWIRQ_B_SLVDONE] = slave_access_done;
   end

   // Mask next value; set and clear in one write cannot happen (separate words)
   always_comb
   begin
      mask_next = mask_reg;
      if (wr_en && paddr == TWIRQ_OFF_IRQ_SET)
         mask_next = mask_reg | (pwdata[TWIRQ_FLAG_W-1:0] & TWIRQ_FLAG_IMPL);
      else if (wr_en && paddr == TWIRQ_OFF_IRQ_CLR)
         mask_next = mask_reg & ~pwdata[TWIRQ_FLAG_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_reg <= TWIRQ_MASK_RST;
      else
         mask_reg <= mask_next;
   end

   // Sticky byte events: rx byte landed, tx byte taken; set beats W1C
   assign evt_set = {tx_take, rx_load};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_reg <= TWIRQ_EVT_RST;
      else if (wr_en && paddr == TWIRQ_OFF_EVT_STATUS)
         evt_reg <= (evt_reg & ~pwdata[TWIRQ_EVT_W-1:0]) | evt_set;
      else
         evt_reg <= evt_reg | evt_set;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_mask_reg <= TWIRQ_EVT_RST;
      else if (wr_en && paddr == TWIRQ_OFF_EVT_MASK)
         evt_mask_reg <= pwdata[TWIRQ_EVT_W-1:0];
   end

   // Flag sources under the mask, plus the sticky events under theirs
   assign irq = (|(flag_register & mask_reg)) || (|(evt_reg & evt_mask_reg));

   // Read decode; write-only registers read as zero
   always_comb
   begin
      rd_next = 32'h0000_0000;
      bad_addr = 1'b0;
      if (paddr == TWIRQ_OFF_FLAGS)
         rd_next[TWIRQ_FLAG_W-1:0] = flag_register;
      else if (paddr == TWIRQ_OFF_IRQ_SET || paddr == TWIRQ_OFF_IRQ_CLR)
         rd_next = 32'h0000_0000;
      else if (paddr == TWIRQ_OFF_IRQ_STATE)
         rd_next[TWIRQ_FLAG_W-1:0] = mask_reg;
      else if (paddr == TWIRQ_OFF_RX_HOLD)
         rd_next[DW-1:0] = rx_byte;
      else if (paddr == TWIRQ_OFF_TX_HOLD)
         rd_next[DW-1:0] = tx_byte;
      else if (paddr == TWIRQ_OFF_EVT_STATUS)
         rd_next[TWIRQ_EVT_W-1:0] = evt_reg;
      else if (paddr == TWIRQ_OFF_EVT_MASK)
         rd_next[TWIRQ_EVT_W-1:0] = evt_mask_reg;
      else
         bad_addr = 1'b1;
   end

   // Read data registered in setup so it is stable in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata_reg <= rd_next;
   end
   assign prdata = prdata_reg;
   assign pslverr = psel && penable && bad_addr;
endmodule // twirq_regs

// ==== twirq_pkg.sv ====
package twirq_pkg;
   // Register byte offsets
   localparam logic [7:0] TWIRQ_OFF_FLAGS = 8'h20;
   localparam logic [7:0] TWIRQ_OFF_IRQ_SET = 8'h24;
   localparam logic [7:0] TWIRQ_OFF_IRQ_CLR = 8'h28;
   localparam logic [7:0] TWIRQ_OFF_IRQ_STATE = 8'h2c;
   localparam logic [7:0] TWIRQ_OFF_RX_HOLD = 8'h30;
   localparam logic [7:0] TWIRQ_OFF_TX_HOLD = 8'h34;
   localparam logic [7:0] TWIRQ_OFF_EVT_STATUS = 8'h38;
   localparam logic [7:0] TWIRQ_OFF_EVT_MASK = 8'h3c;
   // Flag bit positions
   localparam int TWIRQ_B_DONE = 0;
   localparam int TWIRQ_B_RXFULL = 1;
   localparam int TWIRQ_B_TXFREE = 2;
   localparam int TWIRQ_B_SLVADDR = 4;
   localparam int TWIRQ_B_GCALL = 5;
   localparam int TWIRQ_B_OVR = 6;
   localparam int TWIRQ_B_NOT_ACKNOWLEDGED = 8;
   localparam int TWIRQ_B_ARB = 9;
   localparam int TWIRQ_B_WAIT = 10;
   localparam int TWIRQ_B_SLVDONE = 11;
   localparam int TWIRQ_FLAG_W = 12;
   // Bits that exist in the mask / flag layout (bits 3 and 7 unused)
   localparam logic [11:0] TWIRQ_FLAG_IMPL = 12'hf77;
   localparam logic [11:0] TWIRQ_MASK_RST = 12'h000;
   localparam logic [7:0] TWIRQ_BYTE_RST = 8'h00;
   // Event register layout: bit0 rx byte landed, bit1 tx byte taken
   localparam int TWIRQ_EVT_W = 2;
   localparam int TWIRQ_E_RX = 0;
   localparam int TWIRQ_E_TX = 1;
   localparam logic [1:0] TWIRQ_EVT_RST = 2'h0;
endpackage

// ==== twirq_rx_hold.sv ====
`timescale 1ns/1ns
// Receive byte holding register with full flag
module twirq_rx_hold
   import twirq_pkg::*;
#(
   parameter int DW = 8
)
(
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic load, // Shifter delivers a byte
   input wire logic [DW-1:0] load_byte, // Byte from shifter
   input wire logic take, // Software read of the holding register
   output logic [DW-1:0] rx_byte, // Held byte
   output logic full, // Byte waiting
   output logic overrun // Load while still full, one cycle
);
   logic [DW-1:0] byte_reg;
   logic full_reg;

   // Byte store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         byte_reg <= '0;
      else if (load)
         byte_reg <= load_byte;
   end

   // Full flag; a new byte beats a same-cycle read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         full_reg <= 1'b0;
      else if (load)
         full_reg <= 1'b1;
      else if (take)
         full_reg <= 1'b0;
   end

   assign rx_byte = byte_reg;
   assign full = full_reg;
   assign overrun = load && full_reg;
endmodule // twirq_rx_hold

// ==== twirq_tx_hold.sv ====
`timescale 1ns/1ns
// Transmit byte holding register with free flag
module twirq_tx_hold
   import twirq_pkg::*;
#(
   parameter int DW = 8
)
(
   input wire logic pclk, // Bus clock
   input wire logic presetn, // Async reset, active low
   input wire logic put, // Software write
   input wire logic [DW-1:0] put_byte, // Written byte
   input wire logic take, // Shifter takes the byte
   output logic [DW-1:0] tx_byte, // Byte for shifter
   output logic free // Holding register empty
);
   logic [DW-1:0] byte_reg;
   logic free_reg;

   // Byte store
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         byte_reg <= '0;
      else if (put)
         byte_reg <= put_byte;
   end

   // Free after reset; a write holds it low until the shifter takes it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         free_reg <= 1'b1;
      else if (put)
         free_reg <= 1'b0;
      else if (take)
         free_reg <= 1'b1;
   end

   assign tx_byte = byte_reg;
   assign free = free_reg;
endmodule // twirq_tx_hold

// ==== twirq_checker.sv ====
`timescale 1ns/1ns
// Port-level checks; the mask is shadowed here since it is not a port
module twirq_checker
   import twirq_pkg::*;
#(
   parameter int DW = 8
)
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire logic pwrite, // Write
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Wdata
   input wire logic [31:0] prdata, // Rdata
   input wire logic rx_load, // Byte in
   input wire logic [DW-1:0] rx_load_byte, // Rx byte
   input wire logic tx_take, // Byte out
   input wire logic [DW-1:0] tx_byte, // Tx byte
   input wire logic [TWIRQ_FLAG_W-1:0] flag_register, // Flags
   input wire logic irq // Interrupt
);
   logic [11:0] mask_reg;
   logic [DW-1:0] rx_reg;
   logic acc;
   logic put;
   logic rd_rx;
   assign acc = psel && penable;
   assign put = acc && pwrite && paddr == TWIRQ_OFF_TX_HOLD;
   assign rd_rx = acc && !pwrite && paddr == TWIRQ_OFF_RX_HOLD;
   // Mask shadow, only implemented bits can ever be set
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         mask_reg <= TWIRQ_MASK_RST;
      else if (acc && pwrite && paddr == TWIRQ_OFF_IRQ_SET)
         mask_reg <= mask_reg | (pwdata[11:0] & TWIRQ_FLAG_IMPL);
      else if (acc && pwrite && paddr == TWIRQ_OFF_IRQ_CLR)
         mask_reg <= mask_reg & ~pwdata[11:0];
   // Last byte delivered by the shifter
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rx_reg <= TWIRQ_BYTE_RST;
      else if (rx_load)
         rx_reg <= rx_load_byte;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   mask_read_a:
      assert property (acc && !pwrite && paddr == TWIRQ_OFF_IRQ_STATE |-> prdata == mask_reg)
      else $error("mask readback wrong");
   irq_level_a:
      assert property (|(flag_register & mask_reg) |-> irq) else $error("irq missing");
   rx_read_a:
      assert property (rd_rx && !$past(rx_load) |-> prdata == rx_reg)
      else $error("rx byte wrong");
   rx_full_set_a:
      assert property (rx_load |=> flag_register[TWIRQ_B_RXFULL]) else $error("rx not full");
   rx_full_hold_a:
      assert property (flag_register[TWIRQ_B_RXFULL] && !rd_rx |=> flag_register[TWIRQ_B_RXFULL])
      else $error("rx full lost");
   rx_full_clr_a:
      assert property (rd_rx && !rx_load |=> !flag_register[TWIRQ_B_RXFULL])
      else $error("rx full stuck");
   tx_put_a:
      assert property (put |=> tx_byte == $past(pwdata[DW-1:0]) && !flag_register[TWIRQ_B_TXFREE])
      else $error("tx put wrong");
   tx_wait_a:
      assert property (!flag_register[TWIRQ_B_TXFREE] && !tx_take |=> !flag_register[TWIRQ_B_TXFREE])
      else $error("tx free early");
   tx_free_a:
      assert property (tx_take && !put |=> flag_register[TWIRQ_B_TXFREE]) else $error("tx not free");
endmodule // twirq_checker

bind twirq_regs twirq_checker #(.DW(DW)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .rx_load(rx_load), .rx_load_byte(rx_load_byte), .tx_take(tx_take), .tx_byte(tx_byte),
   .flag_register(flag_register), .irq(irq));

// ==== twirq_regs_test.sv ====
`timescale 1ns/1ns
// Directed bench for the mask and holding registers
module twirq_regs_test
   import twirq_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic rx_load = 1'b0;
   logic [7:0] rx_load_byte = 8'h00;
   logic tx_take = 1'b0;
   logic [6:0] src = 7'h00; // Engine sources, flag order
   logic [31:0] prdata, rd;
   logic pready, pslverr, rx_overrun, irq, err;
   logic [7:0] tx_byte;
   logic [11:0] flag_register;
   int error_cnt = 0;
   int num_checks = 0;
   int pos [7] = '{TWIRQ_B_DONE, TWIRQ_B_SLVADDR, TWIRQ_B_GCALL, TWIRQ_B_NOT_ACKNOWLEDGED, TWIRQ_B_ARB,
      TWIRQ_B_WAIT, TWIRQ_B_SLVDONE};
   twirq_regs #(.DW(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_load(rx_load), .rx_load_byte(rx_load_byte), .tx_take(tx_take),
      .tx_byte(tx_byte), .transfer_complete(src[0]), .slave_addressed(src[1]),
      .general_call_seen(src[2]), .not_acknowledged(src[3]), .arbitration_lost(src[4]),
      .clock_stretch_wait(src[5]), .slave_access_done(src[6]), .rx_overrun(rx_overrun),
      .flag_register(flag_register), .irq(irq));
   // 25 MHz bus clock
   always #20 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer; ready is waited for, never assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic load(input logic [7:0] b);
      @(posedge pclk);
      rx_load <= 1'b1;
      rx_load_byte <= b;
      @(posedge pclk);
      rx_load <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic t_mask();
      rd_chk(TWIRQ_OFF_IRQ_STATE, 32'h0);
      chk({20'h0, flag_register}, 32'h4);
      apb(1'b1, TWIRQ_OFF_IRQ_SET, 32'hffff_ffff);
      rd_chk(TWIRQ_OFF_IRQ_STATE, 32'hf77);
      apb(1'b1, TWIRQ_OFF_IRQ_CLR, 32'h301);
      rd_chk(TWIRQ_OFF_IRQ_STATE, 32'hc76);
      apb(1'b1, TWIRQ_OFF_IRQ_SET, 32'h120);
      apb(1'b1, TWIRQ_OFF_IRQ_STATE, 32'hffff_ffff);
      rd_chk(TWIRQ_OFF_IRQ_STATE, 32'hd76);
      apb(1'b1, TWIRQ_OFF_IRQ_CLR, 32'hffff_ffff);
      rd_chk(TWIRQ_OFF_IRQ_STATE, 32'h0);
      apb(1'b0, 8'h44, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   // Each engine source alone, masked then unmasked
   task automatic t_irq();
      for (int i = 0; i < 7; i++)
      begin
         @(posedge pclk);
         src <= 7'h01 << i;
         @(negedge pclk);
         chk({20'h0, flag_register}, 32'h4 | (32'h1 << pos[i]));
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, TWIRQ_OFF_IRQ_SET, 32'h1 << pos[i]);
         chk({31'h0, irq}, 32'h1);
         apb(1'b1, TWIRQ_OFF_IRQ_CLR, 32'h1 << pos[i]);
         chk({31'h0, irq}, 32'h0);
      end
      // Sources drop on a rising edge, like every other input
      @(posedge pclk);
      src <= 7'h00;
   endtask
   task automatic t_rx();
      apb(1'b1, TWIRQ_OFF_IRQ_SET, 32'h2);
      load(8'ha5);
      chk({19'h0, irq, flag_register}, 32'h1006);
      rd_chk(TWIRQ_OFF_RX_HOLD, 32'ha5);
      chk({19'h0, irq, flag_register}, 32'h4);
      load(8'h3c);
      // Third byte lands while the second is unread: overrun pulse
      @(posedge pclk);
      rx_load <= 1'b1;
      rx_load_byte <= 8'hc3;
      @(negedge pclk);
      chk({31'h0, rx_overrun}, 32'h1);
      @(posedge pclk);
      rx_load <= 1'b0;
      @(negedge pclk);
      rd_chk(TWIRQ_OFF_RX_HOLD, 32'hc3);
      rd_chk(TWIRQ_OFF_FLAGS, 32'h44);
      apb(1'b1, TWIRQ_OFF_IRQ_CLR, 32'h2);
   endtask
   task automatic t_tx();
      apb(1'b1, TWIRQ_OFF_IRQ_SET, 32'h4);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, TWIRQ_OFF_TX_HOLD, 32'h1b7);
      chk({24'h0, tx_byte}, 32'hb7);
      chk({19'h0, irq, flag_register}, 32'h0);
      rd_chk(TWIRQ_OFF_TX_HOLD, 32'hb7);
      @(posedge pclk);
      tx_take <= 1'b1;
      @(posedge pclk);
      tx_take <= 1'b0;
      @(negedge pclk);
      chk({19'h0, irq, flag_register}, 32'h1004);
   endtask
   // Sticky byte events under their own mask, cleared by writing ones
   task automatic t_evt();
      apb(1'b1, TWIRQ_OFF_IRQ_CLR, 32'h4);
      chk({31'h0, irq}, 32'h0);
      rd_chk(TWIRQ_OFF_EVT_STATUS, 32'h3);
      apb(1'b1, TWIRQ_OFF_EVT_MASK, 32'h1);
      rd_chk(TWIRQ_OFF_EVT_MASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, TWIRQ_OFF_EVT_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd_chk(TWIRQ_OFF_EVT_STATUS, 32'h2);
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence after a 16-cycle reset
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_mask();
      t_irq();
      t_rx();
      t_tx();
      t_evt();
      wrap_up();
   end
   // Watchdog, well beyond the roughly 150 cycles needed
   initial
   begin
      #100000;
      error_cnt++;
      wrap_up();
   end
endmodule // twirq_regs_test
